// ### charge_setpoint_registers.sv
// Charge voltage and charge current setpoint registers behind an SMBus port.
//
// Contract
// - Voltage code from bits 14:4 only.
// - Voltage word read as millivolts, 16 mV step.
// - Voltage bits binary weighted, 19200 mV maximum.
// - Voltage word bit 15 ignored.
// - Voltage outside 1.024-19.2 V means zero.
// - Voltage register at command 0x15, word write.
// - Reset clears both; charge needs both valid.
// - Voltage register reads back.
// - Current code from bits 12:6 only.
// - Current bits binary weighted, 8128 mA maximum.
// - Current outside 128-8128 mA means zero.
// - Current register at command 0x14, word write.
// - Writing zero current stops charging.
// - Current register reads back.
// - Charge limit is smaller of pin, code.
// - Words move low byte first, high second.
// - One register per write transaction.
// - New setpoint applies after stop condition.
`timescale 1ns/1ps
`default_nettype none
module charge_setpoint_registers #(
    parameter int CODE_W = charge_setpoint_pkg::CURRENT_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_start,
    input wire charge_setpoint_pkg::bus_byte_s wr_byte,
    input wire logic bus_stop,
    input wire logic rd_start,
    input wire logic rd_byte_req,
    input wire logic [CODE_W-1:0] current_limit_pin_voltage,
    output logic byte_ack,
    output logic byte_nack,
    output charge_setpoint_pkg::bus_byte_s rd_byte,
    output charge_setpoint_pkg::converter_drive_s drive
);

    // ------------------------------------------------------------------
    // Types and local state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        WR_IDLE,
        WR_COMMAND,
        WR_DATA_LO,
        WR_DATA_HI,
        WR_COMPLETE,
        WR_DISCARD
    } write_state_e;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_LOW,
        RD_HIGH,
        RD_DONE
    } read_state_e;

    write_state_e wr_state_reg;
    write_state_e wr_state_next;
    read_state_e rd_state_reg;
    logic [7:0] pointer_reg;
    logic [7:0] pending_lo_reg;
    logic [7:0] pending_hi_reg;
    logic [15:0] current_word_reg;
    logic [15:0] voltage_word_reg;
    logic byte_ack_reg;
    logic byte_nack_reg;
    charge_setpoint_pkg::bus_byte_s rd_byte_reg;
    charge_setpoint_pkg::converter_drive_s drive_reg;
    logic commit;
    logic cmd_known;
    logic [15:0] read_word;
    logic [charge_setpoint_pkg::VOLTAGE_W-1:0] voltage_code;
    logic voltage_valid;
    logic [CODE_W-1:0] current_code;
    logic current_valid;
    logic [CODE_W-1:0] effective_code;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Command decode is used by the write path and by the read path.
    function automatic logic is_setpoint_cmd(input logic [7:0] cmd);
        return (cmd == charge_setpoint_pkg::CMD_CHARGE_CURRENT) ||
               (cmd == charge_setpoint_pkg::CMD_CHARGE_VOLTAGE);
    endfunction

    assign cmd_known = is_setpoint_cmd(wr_byte.data);

    // ------------------------------------------------------------------
    // Write transaction sequencer
    // ------------------------------------------------------------------
    // The state walks command, low byte, high byte; anything after the
    // high byte spoils the transaction, so a burst never lands.
    always_comb begin
        wr_state_next = wr_state_reg;
        if (wr_start) begin
            wr_state_next = WR_COMMAND;
        end else if (bus_stop) begin
            wr_state_next = WR_IDLE;
        end else if (wr_byte.valid) begin
            unique case (wr_state_reg)
                WR_IDLE: begin
                    wr_state_next = WR_IDLE;
                end
                WR_COMMAND: begin
                    wr_state_next = cmd_known ? WR_DATA_LO : WR_DISCARD;
                end
                WR_DATA_LO: begin
                    wr_state_next = WR_DATA_HI;
                end
                WR_DATA_HI: begin
                    wr_state_next = WR_COMPLETE;
                end
                WR_COMPLETE: begin
                    wr_state_next = WR_DISCARD;
                end
                WR_DISCARD: begin
                    wr_state_next = WR_DISCARD;
                end
            endcase
        end
    end

    // State register of the write sequencer.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_state_reg <= WR_IDLE;
        end else begin
            wr_state_reg <= wr_state_next;
        end
    end

    assign commit = bus_stop && (wr_state_reg == WR_COMPLETE);

    // ------------------------------------------------------------------
    // Command pointer and pending data bytes
    // ------------------------------------------------------------------
    // The pointer survives the stop, which is how a read selects its
    // register: a write of the command byte alone, then a stop.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pointer_reg <= 8'h00;
        end else if (wr_byte.valid && wr_state_reg == WR_COMMAND) begin
            pointer_reg <= wr_byte.data;
        end
    end

    // Data bytes are held aside until the stop so a broken frame is lost.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pending_lo_reg <= 8'h00;
            pending_hi_reg <= 8'h00;
        end else if (wr_byte.valid && !wr_start && !bus_stop) begin
            if (wr_state_reg == WR_DATA_LO) begin
                pending_lo_reg <= wr_byte.data;
            end
            if (wr_state_reg == WR_DATA_HI) begin
                pending_hi_reg <= wr_byte.data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Setpoint registers
    // ------------------------------------------------------------------
    // clear at reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            current_word_reg <= charge_setpoint_pkg::CURRENT_RESET;
        end else if (commit &&
                     pointer_reg == charge_setpoint_pkg::CMD_CHARGE_CURRENT) begin
            current_word_reg <= {pending_hi_reg, pending_lo_reg};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            voltage_word_reg <= charge_setpoint_pkg::VOLTAGE_RESET;
        end else if (commit &&
                     pointer_reg == charge_setpoint_pkg::CMD_CHARGE_VOLTAGE) begin
            voltage_word_reg <= {pending_hi_reg, pending_lo_reg};
        end
    end

    // ------------------------------------------------------------------
    // Byte acknowledge
    // ------------------------------------------------------------------
    // Each received byte gets exactly one answer pulse on the next cycle.
    // An unknown command and any byte past the high byte are refused.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            byte_ack_reg <= 1'b0;
            byte_nack_reg <= 1'b0;
        end else begin
            byte_ack_reg <= 1'b0;
            byte_nack_reg <= 1'b0;
            if (wr_byte.valid && !wr_start && !bus_stop) begin
                unique case (wr_state_reg)
                    WR_COMMAND: begin
                        byte_ack_reg <= cmd_known;
                        byte_nack_reg <= !cmd_known;
                    end
                    WR_DATA_LO, WR_DATA_HI: begin
                        byte_ack_reg <= 1'b1;
                    end
                    WR_IDLE, WR_COMPLETE, WR_DISCARD: begin
                        byte_nack_reg <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // readback select
    always_comb begin
        if (pointer_reg == charge_setpoint_pkg::CMD_CHARGE_VOLTAGE) begin
            read_word = voltage_word_reg;
        end else begin
            read_word = current_word_reg;
        end
    end

    // Read phase tracker: low byte, then high byte, then filler.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_state_reg <= RD_IDLE;
        end else if (rd_start) begin
            rd_state_reg <= is_setpoint_cmd(pointer_reg) ? RD_LOW : RD_DONE;
        end else if (bus_stop) begin
            rd_state_reg <= RD_IDLE;
        end else if (rd_byte_req) begin
            unique case (rd_state_reg)
                RD_LOW: begin
                    rd_state_reg <= RD_HIGH;
                end
                RD_HIGH, RD_DONE, RD_IDLE: begin
                    rd_state_reg <= RD_DONE;
                end
            endcase
        end
    end

    // Data is answered one cycle after each request. Filler bytes keep
    // the bus released once the word is out, since reads never chain.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_byte_reg <= '0;
        end else begin
            rd_byte_reg.valid <= rd_byte_req && !rd_start && !bus_stop;
            if (rd_byte_req && !rd_start && !bus_stop) begin
                unique case (rd_state_reg)
                    RD_LOW: begin
                        rd_byte_reg.data <= read_word[7:0];
                    end
                    RD_HIGH: begin
                        rd_byte_reg.data <= read_word[15:8];
                    end
                    RD_DONE, RD_IDLE: begin
                        rd_byte_reg.data <= charge_setpoint_pkg::READ_FILL_BYTE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Setpoint decode
    // ------------------------------------------------------------------
    // voltage decode
    setpoint_field_decode #(
        .WORD_W(charge_setpoint_pkg::WORD_W),
        .FIELD_LSB(charge_setpoint_pkg::VOLTAGE_LSB),
        .FIELD_W(charge_setpoint_pkg::VOLTAGE_W),
        .MIN_CODE(charge_setpoint_pkg::VOLTAGE_MIN_CODE),
        .MAX_CODE(charge_setpoint_pkg::VOLTAGE_MAX_CODE)
    ) voltage_decode (
        .word(voltage_word_reg),
        .code(voltage_code),
        .valid(voltage_valid)
    );

    setpoint_field_decode #(
        .WORD_W(charge_setpoint_pkg::WORD_W),
        .FIELD_LSB(charge_setpoint_pkg::CURRENT_LSB),
        .FIELD_W(CODE_W),
        .MIN_CODE(charge_setpoint_pkg::CURRENT_MIN_CODE),
        .MAX_CODE(charge_setpoint_pkg::CURRENT_MAX_CODE)
    ) current_decode (
        .word(current_word_reg),
        .code(current_code),
        .valid(current_valid)
    );

    current_limit_select #(
        .CODE_W(CODE_W)
    ) limit_select (
        .pin_code(current_limit_pin_voltage),
        .reg_code(current_code),
        .limit_code(effective_code)
    );

    // ------------------------------------------------------------------
    // Converter drive
    // ------------------------------------------------------------------
    // Registered so the converters see one clean edge after each commit;
    // the cost is a single cycle of extra latency.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            drive_reg <= '0;
        end else begin
            drive_reg.voltage_converter_code <= voltage_code;
            drive_reg.current_converter_code <= current_code;
            drive_reg.effective_current_code <= effective_code;
            drive_reg.charge_enable <= voltage_valid && current_valid;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign byte_ack = byte_ack_reg;
    assign byte_nack = byte_nack_reg;
    assign rd_byte = rd_byte_reg;
    assign drive = drive_reg;

endmodule
`default_nettype wire

// ### charge_setpoint_pkg.sv
// Package with command codes, field layouts and decode limits of the setpoints.
package charge_setpoint_pkg;

    // ------------------------------------------------------------------
    // Command codes and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_CHARGE_CURRENT = 8'h14;
    localparam logic [7:0] CMD_CHARGE_VOLTAGE = 8'h15;
    localparam logic [15:0] CURRENT_RESET = 16'h0000;
    localparam logic [15:0] VOLTAGE_RESET = 16'h0000;
    localparam logic [7:0] READ_FILL_BYTE = 8'hFF;

    // ------------------------------------------------------------------
    // Field layouts of the two setpoint words
    // ------------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int VOLTAGE_LSB = 4;
    localparam int VOLTAGE_W = 11;
    localparam int CURRENT_LSB = 6;
    localparam int CURRENT_W = 7;

    // ------------------------------------------------------------------
    // Scaling and legal ranges, as printed, with derived code limits
    // ------------------------------------------------------------------
    localparam int VOLTAGE_STEP_MV = 16;
    localparam int VOLTAGE_MIN_MV = 1024;
    localparam int VOLTAGE_MAX_MV = 19200;
    localparam int CURRENT_STEP_MA = 64;
    localparam int CURRENT_MIN_MA = 128;
    localparam int CURRENT_MAX_MA = 8128;
    localparam int VOLTAGE_MIN_CODE = VOLTAGE_MIN_MV / VOLTAGE_STEP_MV;
    localparam int VOLTAGE_MAX_CODE = VOLTAGE_MAX_MV / VOLTAGE_STEP_MV;
    localparam int CURRENT_MIN_CODE = CURRENT_MIN_MA / CURRENT_STEP_MA;
    localparam int CURRENT_MAX_CODE = CURRENT_MAX_MA / CURRENT_STEP_MA;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [VOLTAGE_W-1:0] voltage_converter_code;
        logic [CURRENT_W-1:0] current_converter_code;
        logic [CURRENT_W-1:0] effective_current_code;
        logic charge_enable;
    } converter_drive_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } bus_byte_s;

endpackage

// ### setpoint_field_decode.sv
// Extracts a setpoint code field and forces it to zero when out of range.
`timescale 1ns/1ps
`default_nettype none
module setpoint_field_decode #(
    parameter int WORD_W = 16,
    parameter int FIELD_LSB = 4,
    parameter int FIELD_W = 11,
    parameter int MIN_CODE = 64,
    parameter int MAX_CODE = 1200
) (
    input wire logic [WORD_W-1:0] word,
    output logic [FIELD_W-1:0] code,
    output logic valid
);

    // ------------------------------------------------------------------
    // Range check on the used field only
    // ------------------------------------------------------------------
    localparam logic [FIELD_W-1:0] MIN_C = FIELD_W'(MIN_CODE);
    localparam logic [FIELD_W-1:0] MAX_C = FIELD_W'(MAX_CODE);
    logic [FIELD_W-1:0] field;

    // Bits below and above the field never reach the converter.
    assign field = word[FIELD_LSB +: FIELD_W];
    assign valid = (field >= MIN_C) && (field <= MAX_C);
    assign code = valid ? field : '0;

endmodule
`default_nettype wire

// ### current_limit_select.sv
// Picks the lower of the pin-derived and register-derived charge limits.
`timescale 1ns/1ps
`default_nettype none
module current_limit_select #(
    parameter int CODE_W = 7
) (
    input wire logic [CODE_W-1:0] pin_code,
    input wire logic [CODE_W-1:0] reg_code,
    output logic [CODE_W-1:0] limit_code
);

    // ------------------------------------------------------------------
    // Minimum selection
    // ------------------------------------------------------------------
    // A zero register code wins, so a stop request always ends charging.
    assign limit_code = (pin_code < reg_code) ? pin_code : reg_code;

endmodule
`default_nettype wire

// ### charge_setpoint_registers_asserts.sv
// Concurrent checks on the ports of the charge setpoint register bank.
`timescale 1ns/1ps
`default_nettype none
module charge_setpoint_registers_asserts #(
    parameter int CODE_W = charge_setpoint_pkg::CURRENT_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_start,
    input wire charge_setpoint_pkg::bus_byte_s wr_byte,
    input wire logic bus_stop,
    input wire logic rd_start,
    input wire logic rd_byte_req,
    input wire logic [CODE_W-1:0] current_limit_pin_voltage,
    input wire logic byte_ack,
    input wire logic byte_nack,
    input wire charge_setpoint_pkg::bus_byte_s rd_byte,
    input wire charge_setpoint_pkg::converter_drive_s drive
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    // One clock domain, so clocking and reset are declared once.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_ack_after_byte;
        byte_ack |-> $past(wr_byte.valid);
    endproperty
    a_ack_after_byte: assert property (p_ack_after_byte)
        else $error("byte_ack without a byte one cycle before");
    property p_ack_nack_apart;
        !(byte_ack && byte_nack);
    endproperty
    a_ack_nack_apart: assert property (p_ack_nack_apart)
        else $error("byte_ack and byte_nack together");
    property p_rd_after_req;
        rd_byte.valid |-> $past(rd_byte_req);
    endproperty
    a_rd_after_req: assert property (p_rd_after_req)
        else $error("read byte without a request");
    // The guard skips the edge that still sees pre-reset data.
    property p_rd_data_holds;
        !rd_byte.valid && !$past(rst) |-> $stable(rd_byte.data);
    endproperty
    a_rd_data_holds: assert property (p_rd_data_holds)
        else $error("read data moved without an answer");
    property p_volt_range;
        drive.voltage_converter_code != 11'h000 |->
            drive.voltage_converter_code >=
                charge_setpoint_pkg::VOLTAGE_MIN_CODE &&
            drive.voltage_converter_code <=
                charge_setpoint_pkg::VOLTAGE_MAX_CODE;
    endproperty
    a_volt_range: assert property (p_volt_range)
        else $error("voltage code outside the legal range");
    property p_curr_range;
        drive.current_converter_code != 7'h00 |->
            drive.current_converter_code >=
                charge_setpoint_pkg::CURRENT_MIN_CODE;
    endproperty
    a_curr_range: assert property (p_curr_range)
        else $error("current code below the legal range");
    property p_eff_min;
        drive.effective_current_code ==
            (($past(current_limit_pin_voltage) <
              drive.current_converter_code) ?
             $past(current_limit_pin_voltage) :
             drive.current_converter_code);
    endproperty
    a_eff_min: assert property (p_eff_min)
        else $error("effective code is not the lower limit");
    property p_enable;
        drive.charge_enable == (drive.voltage_converter_code != 11'h000 &&
            drive.current_converter_code != 7'h00);
    endproperty
    a_enable: assert property (p_enable)
        else $error("charge_enable disagrees with the codes");
    property p_commit_after_stop;
        $changed({drive.voltage_converter_code,
                  drive.current_converter_code}) |->
            $past(bus_stop, 2) || $past(rst);
    endproperty
    a_commit_after_stop: assert property (p_commit_after_stop)
        else $error("setpoint changed without a stop");

    // ------------------------------------------------------------------
    // Coverage of the main scenarios
    // ------------------------------------------------------------------
    c_write_ack: cover property (byte_ack);
    c_read_byte: cover property (rd_byte.valid);
    c_charge_on: cover property (drive.charge_enable);
endmodule
bind charge_setpoint_registers charge_setpoint_registers_asserts #(
    .CODE_W(CODE_W)
) charge_setpoint_registers_asserts_i (
    .ref_clk(ref_clk), .rst(rst), .wr_start(wr_start),
    .wr_byte(wr_byte), .bus_stop(bus_stop), .rd_start(rd_start),
    .rd_byte_req(rd_byte_req),
    .current_limit_pin_voltage(current_limit_pin_voltage),
    .byte_ack(byte_ack), .byte_nack(byte_nack), .rd_byte(rd_byte),
    .drive(drive)
);
`default_nettype wire

// ### smbus_host_model.sv
// Byte-level model of the host and bus engine in front of the setpoints.
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
    input wire logic ref_clk,
    input wire logic byte_ack,
    input wire logic byte_nack,
    input wire charge_setpoint_pkg::bus_byte_s rd_byte,
    output logic wr_start,
    output charge_setpoint_pkg::bus_byte_s wr_byte,
    output logic bus_stop,
    output logic rd_start,
    output logic rd_byte_req
);
    initial begin
        wr_start = 1'b0;
        wr_byte = '{valid: 1'b0, data: 8'h5A};
        bus_stop = 1'b0;
        rd_start = 1'b0;
        rd_byte_req = 1'b0;
    end

    // Released data shows the inverse; a missing answer reads unknown.
    task automatic send_byte(input logic [7:0] d, output logic a);
        @(posedge ref_clk) wr_byte <= '{valid: 1'b1, data: d};
        @(posedge ref_clk) wr_byte <= '{valid: 1'b0, data: ~d};
        #1 a = byte_ack ? 1'b1 : (byte_nack ? 1'b0 : 1'bx);
    endtask

    // command, low byte, high byte, one register.
    // A count above two adds an illegal extra byte; the host is asked to.
    task automatic write_frame(input logic [7:0] cmd, input logic [15:0] w,
                               input int n, output logic [3:0] acks);
        logic [7:0] b [4];
        b = '{cmd, w[7:0], w[15:8], ~w[15:8]};
        acks = 4'h0;
        @(posedge ref_clk) wr_start <= 1'b1;
        @(posedge ref_clk) wr_start <= 1'b0;
        for (int i = 0; i <= n; i++) begin
            send_byte(b[i], acks[i]);
        end
        @(posedge ref_clk) bus_stop <= 1'b1;
        @(posedge ref_clk) bus_stop <= 1'b0;
        @(posedge ref_clk) #1;
    endtask

    // Select by command-only write, then low, high and one extra.
    task automatic read_word(input logic [7:0] cmd, output logic [23:0] b);
        logic [3:0] acks;
        write_frame(cmd, 16'h0000, 0, acks);
        @(posedge ref_clk) rd_start <= 1'b1;
        @(posedge ref_clk) rd_start <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk) rd_byte_req <= 1'b1;
            @(posedge ref_clk) rd_byte_req <= 1'b0;
            #1 b[8*i +: 8] = (rd_byte.valid === 1'b1) ? rd_byte.data : 8'hXX;
        end
    endtask
endmodule
`default_nettype wire

// ### charge_setpoint_registers_tb.sv
// Self-checking bench for the charge setpoint register bank.
`timescale 1ns/1ps
`default_nettype none
module charge_setpoint_registers_tb;
    typedef struct packed {
        logic [15:0] volt;
        logic [15:0] cur;
        logic [6:0] pin;
        logic [10:0] vcode;
        logic [6:0] ccode;
        logic [6:0] eff;
        logic en;
    } row_s;

    logic ref_clk;
    logic rst;
    logic [6:0] pin;
    logic wr_start, bus_stop, rd_start, rd_byte_req, byte_ack, byte_nack;
    charge_setpoint_pkg::bus_byte_s wr_byte, rd_byte;
    charge_setpoint_pkg::converter_drive_s drive;
    logic [3:0] acks;
    logic [23:0] rb;
    int failures = 0;
    int total_checks = 0, cycles = 0;
    // Words, limit pin, then expected codes and enable.
    row_s rows [7] = '{
        '{16'h41A0, 16'h0400, 7'h7F, 11'h41A, 7'h10, 7'h10, 1'b1},
        '{16'hC40F, 16'hE0BF, 7'h05, 11'h440, 7'h02, 7'h02, 1'b1},
        '{16'h4B00, 16'h1FC0, 7'h20, 11'h4B0, 7'h7F, 7'h20, 1'b1},
        '{16'h4B10, 16'h0040, 7'h10, 11'h000, 7'h00, 7'h00, 1'b0},
        '{16'h03F0, 16'h0080, 7'h7F, 11'h000, 7'h02, 7'h02, 1'b0},
        '{16'h0400, 16'h0080, 7'h01, 11'h040, 7'h02, 7'h01, 1'b1},
        '{16'h0400, 16'h0000, 7'h7F, 11'h040, 7'h00, 7'h00, 1'b0}
    };

    charge_setpoint_registers charge_setpoint_registers_i (
        .ref_clk(ref_clk), .rst(rst), .wr_start(wr_start),
        .wr_byte(wr_byte), .bus_stop(bus_stop), .rd_start(rd_start),
        .rd_byte_req(rd_byte_req), .current_limit_pin_voltage(pin),
        .byte_ack(byte_ack), .byte_nack(byte_nack), .rd_byte(rd_byte),
        .drive(drive)
    );
    smbus_host_model smbus_host_model_i (
        .ref_clk(ref_clk), .byte_ack(byte_ack), .byte_nack(byte_nack),
        .rd_byte(rd_byte), .wr_start(wr_start), .wr_byte(wr_byte),
        .bus_stop(bus_stop), .rd_start(rd_start), .rd_byte_req(rd_byte_req)
    );

    // ------------------------------------------------------------------
    // Clock, comparison and closing report
    // ------------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t %s seen %h expected %h", $time, what,
                     seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // A hung handshake would stall the run for ever.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            final_report();
        end
    end

    task automatic check_word(input logic [7:0] cmd, input logic [15:0] w);
        smbus_host_model_i.read_word(cmd, rb);
        check(rb, {charge_setpoint_pkg::READ_FILL_BYTE, w},
              "readback");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        pin = 7'h7F;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk) #1;
        check(drive, 26'h0, "drive after reset");
        check_word(charge_setpoint_pkg::CMD_CHARGE_VOLTAGE, 16'h0000);
        check_word(charge_setpoint_pkg::CMD_CHARGE_CURRENT, 16'h0000);
        for (int i = 0; i < 7; i++) begin
            @(posedge ref_clk) pin <= rows[i].pin;
            smbus_host_model_i.write_frame(
                charge_setpoint_pkg::CMD_CHARGE_VOLTAGE, rows[i].volt, 2, acks);
            check(acks, 4'h7, "voltage frame acks");
            smbus_host_model_i.write_frame(
                charge_setpoint_pkg::CMD_CHARGE_CURRENT, rows[i].cur, 2, acks);
            check(acks, 4'h7, "current frame acks");
            check(drive.voltage_converter_code, rows[i].vcode, "vcode");
            check(drive.current_converter_code, rows[i].ccode, "ccode");
            check(drive.effective_current_code, rows[i].eff, "limit");
            check(drive.charge_enable, rows[i].en, "enable");
            check_word(charge_setpoint_pkg::CMD_CHARGE_VOLTAGE, rows[i].volt);
            check_word(charge_setpoint_pkg::CMD_CHARGE_CURRENT, rows[i].cur);
        end
        // Unknown command: every byte refused, and reads give filler only.
        smbus_host_model_i.write_frame(8'h16, 16'h1234, 2, acks);
        check(acks, 4'h0, "unknown command acks");
        smbus_host_model_i.read_word(8'h16, rb);
        check(rb, 24'hFFFFFF, "unknown pointer read");
        // A frame stopped after the low byte commits nothing.
        smbus_host_model_i.write_frame(
            charge_setpoint_pkg::CMD_CHARGE_VOLTAGE, 16'h4B00, 1, acks);
        check(drive.voltage_converter_code, 11'h040, "short frame");
        check_word(charge_setpoint_pkg::CMD_CHARGE_VOLTAGE, 16'h0400);
        // A byte past the high byte is refused and the frame dropped.
        smbus_host_model_i.write_frame(
            charge_setpoint_pkg::CMD_CHARGE_CURRENT, 16'h1FC0, 3, acks);
        check(acks, 4'h7, "overlong frame acks");
        check(drive.current_converter_code, 7'h00, "overlong frame");
        check_word(charge_setpoint_pkg::CMD_CHARGE_CURRENT, 16'h0000);
        // A second reset in mid-run clears both words again.
        @(posedge ref_clk) rst <= 1'b1;
        @(posedge ref_clk) rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 check(drive, 26'h0, "drive after second reset");
        check_word(charge_setpoint_pkg::CMD_CHARGE_VOLTAGE, 16'h0000);
        check_word(charge_setpoint_pkg::CMD_CHARGE_CURRENT, 16'h0000);
        final_report();
    end
endmodule
`default_nettype wire
